// *** rtl/bdt_consts.vh ***
`ifndef BDT_CONSTS_VH
`define BDT_CONSTS_VH

// ==========================================
// Register map
`define BDT_ADDR_W            5
`define BDT_OFS_TIMING_SEL    5'h04
`define BDT_OFS_TIMING_SET_A  5'h05
`define BDT_OFS_TIMING_SET_B  5'h06
`define BDT_BANK_ACTIVE       1'b0
`define BDT_BANK_FREEWHEEL    1'b1

// ==========================================
// Reset values and write masks
`define BDT_SET_A_RESET       16'h4924
`define BDT_SET_B_RESET       16'h0924
`define BDT_SEL_RESET         16'h0000
`define BDT_SET_A_WMASK       16'h7fff
`define BDT_SET_B_WMASK       16'h01ff

// ==========================================
// Field positions
`define BDT_DELAY1_LSB        0
`define BDT_BLANK1_LSB        3
`define BDT_DELAY2_LSB        6
`define BDT_BLANK2_LSB        9
`define BDT_DELAY3_LSB        12
`define BDT_B_DELAY4_LSB      0
`define BDT_B_BLANK3_LSB      3
`define BDT_B_BLANK4_LSB      6

// ==========================================
// Durations in ns
`define BDT_CLK_NS            10
`define BDT_T_375_NS          375
`define BDT_T_625_NS          625
`define BDT_T_1000_NS         1000
`define BDT_T_1250_NS         1250
`define BDT_T_1500_NS         1500
`define BDT_T_2000_NS         2000
`define BDT_T_3000_NS         3000
`define BDT_T_4000_NS         4000
`define BDT_T_16000_NS        16000
`define BDT_CYC(t)            (((t) + `BDT_CLK_NS - 1) / `BDT_CLK_NS)

`endif

// *** rtl/bdt_timer.v ***
`timescale 1ns/1ns
`default_nettype none

module bdt_timer #(
    parameter CW = 11
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          ce,
    input  wire          start,
    input  wire [CW-1:0] cycles,
    output wire          busy
);
    // ==========================================
    // Down counter
    reg [CW-1:0] cnt_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= {CW{1'b0}};
        end else if (ce) begin
            if (start) begin
                cnt_reg <= cycles;
            end else if (cnt_reg != {CW{1'b0}}) begin
                cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    assign busy = (cnt_reg != {CW{1'b0}});
endmodule

`default_nettype wire

// *** rtl/bdt_bridge_timing.v ***
`include "bdt_consts.vh"
`timescale 1ns/1ns
`default_nettype none
// Function
// [RL1] Bridge 1 two-bit code picks timing set 1..4, default set 1
// [RL2] Active set register: bank 0, offset 00101, reset 0x4924, drives active FETs
// [RL3] Freewheel set register: bank 1, offset 00101, reset 0x4924, drives freewheel FETs
// [RL4] Bit 15 of both set registers reads zero, writes ignored
// [RL5] Active fields: delay3 14:12, blank2 11:9, delay2 8:6, blank1 5:3, delay1 2:0
// [RL6] Freewheel fields use the same bit placement
// [RL7] All delay and blank fields reset to code 100, 2000 ns
// [RL8] Active delay codes map 375 ns up to 16 us
// [RL9] Active blank codes map 625 ns up to 16 us
// [RL10] Freewheel delay codes use the active delay mapping
// [RL11] Host keeps drive current below 30 mA when selecting 16 us
// [RL12] Delay4, blank3, blank4 come from a separate register
// [RL13] Freewheel blank codes map 625 ns up to 16 us
// [RL14] Durations are clock counts, changes apply at next switching event

module bdt_bridge_timing #(
    parameter CW = 11
) (
    input  wire        REF_CLK,
    input  wire        RST_N,
    input  wire        CE,
    input  wire        WR_EN,
    input  wire        RD_EN,
    input  wire        BANK_SEL,
    input  wire [4:0]  ADDR,
    input  wire [15:0] WDATA,
    input  wire        SWITCH_EVT,
    input  wire        SWITCH_FW,
    output reg  [15:0] RDATA,
    output reg         RVALID,
    output reg         DELAY_ACTIVE,
    output reg         BLANK_ACTIVE
);
    // ==========================================
    // Registers
    reg [15:0] sel_reg;
    reg [15:0] act_a_reg;
    reg [15:0] fw_a_reg;
    reg [15:0] act_b_reg;
    reg [15:0] fw_b_reg;
    reg [15:0] rdata_next;

    wire hit_sel = (ADDR == `BDT_OFS_TIMING_SEL);
    wire hit_a   = (ADDR == `BDT_OFS_TIMING_SET_A);
    wire hit_b   = (ADDR == `BDT_OFS_TIMING_SET_B);
    wire is_fw   = (BANK_SEL == `BDT_BANK_FREEWHEEL);

    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sel_reg   <= `BDT_SEL_RESET;
            act_a_reg <= `BDT_SET_A_RESET; // RL2 RL7
            fw_a_reg  <= `BDT_SET_A_RESET; // RL3 RL7
            act_b_reg <= `BDT_SET_B_RESET;
            fw_b_reg  <= `BDT_SET_B_RESET;
        end else if (CE && WR_EN) begin
            if (hit_sel) begin
                sel_reg <= WDATA;
            end
            if (hit_a && !is_fw) begin
                act_a_reg <= WDATA & `BDT_SET_A_WMASK; // RL2 RL4
            end
            if (hit_a && is_fw) begin
                fw_a_reg <= WDATA & `BDT_SET_A_WMASK; // RL3 RL4
            end
            if (hit_b && !is_fw) begin
                act_b_reg <= WDATA & `BDT_SET_B_WMASK; // RL12
            end
            if (hit_b && is_fw) begin
                fw_b_reg <= WDATA & `BDT_SET_B_WMASK; // RL12
            end
        end
    end

    // ==========================================
    // Read path
    always @* begin
        rdata_next = 16'h0000;
        if (hit_sel) begin
            rdata_next = sel_reg;
        end else if (hit_a) begin
            rdata_next = is_fw ? fw_a_reg : act_a_reg; // RL4
        end else if (hit_b) begin
            rdata_next = is_fw ? fw_b_reg : act_b_reg;
        end
    end

    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA  <= 16'h0000;
            RVALID <= 1'b0;
        end else if (CE) begin
            RVALID <= RD_EN;
            if (RD_EN) begin
                RDATA <= rdata_next;
            end
        end
    end

    // ==========================================
    // Code to cycle maps
    function [CW-1:0] ns_to_cyc;
        input [31:0] ns;
        reg   [31:0] full;
        begin
            full      = `BDT_CYC(ns);
            ns_to_cyc = full[CW-1:0];
        end
    endfunction

    function [CW-1:0] delay_cyc;
        input [2:0]  code;
        reg   [31:0] ns;
        begin
            case (code)
                3'h0: ns = `BDT_T_375_NS;
                3'h1: ns = `BDT_T_625_NS;
                3'h2: ns = `BDT_T_1000_NS;
                3'h3: ns = `BDT_T_1500_NS;
                3'h4: ns = `BDT_T_2000_NS;
                3'h5: ns = `BDT_T_3000_NS;
                3'h6: ns = `BDT_T_4000_NS;
                default: ns = `BDT_T_16000_NS;
            endcase
            delay_cyc = ns_to_cyc(ns);
        end
    endfunction

    function [CW-1:0] blank_cyc;
        input [2:0]  code;
        reg   [31:0] ns;
        begin
            case (code)
                3'h0: ns = `BDT_T_625_NS;
                3'h1: ns = `BDT_T_1000_NS;
                3'h2: ns = `BDT_T_1250_NS;
                3'h3: ns = `BDT_T_1500_NS;
                3'h4: ns = `BDT_T_2000_NS;
                3'h5: ns = `BDT_T_3000_NS;
                3'h6: ns = `BDT_T_4000_NS;
                default: ns = `BDT_T_16000_NS;
            endcase
            blank_cyc = ns_to_cyc(ns);
        end
    endfunction

    // ==========================================
    // Set selection for bridge 1
    wire [1:0]  bridge1_timing_select = sel_reg[1:0];
    wire [15:0] set_a = SWITCH_FW ? fw_a_reg : act_a_reg; // RL2 RL3
    wire [15:0] set_b = SWITCH_FW ? fw_b_reg : act_b_reg;
    reg  [2:0]  dly_code;
    reg  [2:0]  blk_code;

    always @* begin
        dly_code = set_a[`BDT_DELAY1_LSB +: 3];
        blk_code = set_a[`BDT_BLANK1_LSB +: 3];
        case (bridge1_timing_select) // RL1
            2'b00: begin
                dly_code = set_a[`BDT_DELAY1_LSB +: 3]; // RL5 RL6
                blk_code = set_a[`BDT_BLANK1_LSB +: 3];
            end
            2'b01: begin
                dly_code = set_a[`BDT_DELAY2_LSB +: 3]; // RL5 RL6
                blk_code = set_a[`BDT_BLANK2_LSB +: 3];
            end
            2'b10: begin
                dly_code = set_a[`BDT_DELAY3_LSB +: 3]; // RL5 RL6
                blk_code = set_b[`BDT_B_BLANK3_LSB +: 3]; // RL12
            end
            default: begin
                dly_code = set_b[`BDT_B_DELAY4_LSB +: 3]; // RL12
                blk_code = set_b[`BDT_B_BLANK4_LSB +: 3];
            end
        endcase
    end

    // Durations sampled only at a switching event
    wire [CW-1:0] dly_cycles = delay_cyc(dly_code); // RL8 RL10 RL14
    wire [CW-1:0] blk_cycles = blank_cyc(blk_code); // RL9 RL13 RL14
    wire          dly_busy;
    wire          blk_busy;

    bdt_timer #(.CW(CW)) u_delay (
        .clk    (REF_CLK),
        .rst_n  (RST_N),
        .ce     (CE),
        .start  (SWITCH_EVT),
        .cycles (dly_cycles),
        .busy   (dly_busy)
    );

    bdt_timer #(.CW(CW)) u_blank (
        .clk    (REF_CLK),
        .rst_n  (RST_N),
        .ce     (CE),
        .start  (SWITCH_EVT),
        .cycles (blk_cycles),
        .busy   (blk_busy)
    );

    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            DELAY_ACTIVE <= 1'b0;
            BLANK_ACTIVE <= 1'b0;
        end else if (CE) begin
            DELAY_ACTIVE <= dly_busy; // RL14
            BLANK_ACTIVE <= blk_busy;
        end
    end
endmodule

`default_nettype wire

// *** dv/bdt_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module bdt_props (
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    input wire logic        CE,
    input wire logic        RD_EN,
    input wire logic [4:0]  ADDR,
    input wire logic        SWITCH_EVT,
    input wire logic [15:0] RDATA,
    input wire logic        RVALID,
    input wire logic        DELAY_ACTIVE,
    input wire logic        BLANK_ACTIVE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    sequence evt_s; CE && SWITCH_EVT; endsequence
    sequence on_s; ##2 (DELAY_ACTIVE && BLANK_ACTIVE); endsequence
    AST_RD_ANS: assert property (CE && RD_EN |=> RVALID)
        else $error("read not answered");
    AST_NO_ANS: assert property (CE && !RD_EN |=> !RVALID)
        else $error("answer without read");
    AST_RD_HOLD: assert property (CE && !RD_EN |=> $stable(RDATA))
        else $error("read data moved");
    AST_RSV: assert property (RVALID && $past(RD_EN && ADDR == 5'h05) |-> !RDATA[15])
        else $error("reserved bit set");
    AST_START: assert property (evt_s |-> on_s)
        else $error("timers not started");
    AST_D_CAUSE: assert property ($rose(DELAY_ACTIVE) |-> $past(SWITCH_EVT, 2))
        else $error("delay without event");
    AST_D_MIN: assert property ($rose(DELAY_ACTIVE) |-> DELAY_ACTIVE[*8])
        else $error("delay too short");
    AST_B_MIN: assert property ($rose(BLANK_ACTIVE) |-> BLANK_ACTIVE[*8])
        else $error("blank too short");
    AST_FREEZE: assert property (!CE |=> $stable(RVALID) && $stable(DELAY_ACTIVE) && $stable(BLANK_ACTIVE))
        else $error("state moved while disabled");
endmodule
bind bdt_bridge_timing bdt_props u_props (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE),
    .RD_EN(RD_EN), .ADDR(ADDR), .SWITCH_EVT(SWITCH_EVT), .RDATA(RDATA),
    .RVALID(RVALID), .DELAY_ACTIVE(DELAY_ACTIVE), .BLANK_ACTIVE(BLANK_ACTIVE));
`default_nettype wire

// *** dv/bdt_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// Host side; drive current limits left to other registers
module bdt_host (
    input  wire logic        ref_clk,
    input  wire logic [15:0] rdata,
    input  wire logic        rvalid,
    output var  logic        wr_en,
    output var  logic        rd_en,
    output var  logic        bank_sel,
    output var  logic [4:0]  addr,
    output var  logic [15:0] wdata
);
    initial begin
        {wr_en, rd_en, bank_sel, addr, wdata} = '0;
    end
    task automatic wr(input logic bk, input logic [4:0] ad, input logic [15:0] d);
        @(negedge ref_clk);
        {bank_sel, addr, wdata, wr_en} = {bk, ad, d, 1'b1};
        @(negedge ref_clk);
        {wr_en, wdata} = {1'b0, ~d};
    endtask
    task automatic rd(input logic bk, input logic [4:0] ad, output logic [15:0] d);
        @(negedge ref_clk);
        {bank_sel, addr, rd_en} = {bk, ad, 1'b1};
        @(negedge ref_clk);
        rd_en = 0;
        d = (rvalid === 1'b1) ? rdata : 16'hxxxx;
    endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %0h got %0h", n, e, s); end end
module testbench;
    logic        clk = 0, rst_n = 0, evt = 0, fw = 0, ce = 1, wr, rd, bk, rv, dly, blk;
    logic [4:0]  ad;
    logic [15:0] wd, rdat, v, a, b;
    logic [2:0]  dc, bc;
    int num_errors = 0, total_checks = 0, nd, nb;
    int dn[8] = '{375, 625, 1000, 1500, 2000, 3000, 4000, 16000};
    int bn[8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000, 16000};
    always #5 clk = ~clk;
    bdt_host host (.ref_clk(clk), .rdata(rdat), .rvalid(rv), .wr_en(wr), .rd_en(rd),
        .bank_sel(bk), .addr(ad), .wdata(wd));
    bdt_bridge_timing uut (.REF_CLK(clk), .RST_N(rst_n), .CE(ce), .WR_EN(wr), .RD_EN(rd),
        .BANK_SEL(bk), .ADDR(ad), .WDATA(wd), .SWITCH_EVT(evt), .SWITCH_FW(fw),
        .RDATA(rdat), .RVALID(rv), .DELAY_ACTIVE(dly), .BLANK_ACTIVE(blk));
    function automatic int cyc(input int ns);
        return (ns + 9) / 10;
    endfunction
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check_reset;
        host.rd(0, 5'h05, v); `CHK("set a act", 16'h4924, v)
        host.rd(1, 5'h05, v); `CHK("set a fw", 16'h4924, v)
        host.rd(0, 5'h06, v); `CHK("set b act", 16'h0924, v)
        host.rd(1, 5'h06, v); `CHK("set b fw", 16'h0924, v)
        host.rd(1, 5'h04, v); `CHK("select", 16'h0000, v)
    endtask
    task automatic run_event(input logic f, input logic freeze);
        @(negedge clk) {fw, evt} = {f, 1'b1};
        @(negedge clk) evt = 0;
        {nd, nb} = '0;
        for (int j = 0; j < 1612; j++) begin
            @(negedge clk);
            nd += dly;
            nb += blk;
            ce = !(freeze && j >= 10 && j < 17);
        end
    endtask
    initial begin
        #700_000;
        num_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(82206));
        repeat (10) @(negedge clk);
        rst_n = 1;
        check_reset();
        host.wr(0, 5'h1f, 16'hffff);
        host.rd(0, 5'h1f, v); `CHK("unmapped", 16'h0000, v)
        ce = 0;
        host.wr(0, 5'h05, 16'h1234);
        ce = 1;
        host.rd(0, 5'h05, v); `CHK("frozen write", 16'h4924, v)
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            a = (i == 0) ? 16'hffff : 16'($urandom);
            b = (i == 0) ? 16'hffff : 16'($urandom);
            host.wr(i[4], 5'h05, a);
            host.wr(i[4], 5'h06, b);
            host.wr(i[3], 5'h04, {14'h0, i[1:0]});
            host.rd(i[4], 5'h05, v); `CHK("set a", a & 16'h7fff, v)
            host.rd(i[4], 5'h06, v); `CHK("set b", b & 16'h01ff, v)
            host.rd(i[2], 5'h04, v); `CHK("select", {14'h0, i[1:0]}, v)
            case (i[1:0])
                0: {dc, bc} = {a[2:0], a[5:3]};
                1: {dc, bc} = {a[8:6], a[11:9]};
                2: {dc, bc} = {a[14:12], b[5:3]};
                default: {dc, bc} = {b[2:0], b[8:6]};
            endcase
            run_event(i[4], i % 5 == 3);
            `CHK("delay len", cyc(dn[dc]) + ((i % 5 == 3) ? 7 : 0), nd)
            `CHK("blank len", cyc(bn[bc]) + ((i % 5 == 3) ? 7 : 0), nb)
        end
        $display("test timing done");
        rst_n = 0;
        repeat (3) @(negedge clk);
        rst_n = 1;
        check_reset();
        run_event(0, 0);
        `CHK("default delay", cyc(2000), nd)
        `CHK("default blank", cyc(2000), nb)
        $display("test mid reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
